// File: common/adc_cfg_pkg.sv
// Constants shared by the serial configuration port and its host controller.
// Assumes both ends run on one 25 MHz clock domain each.
package adc_cfg_pkg;

  // ----------------------------------------------------------------
  // Device register map
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_POWER_STATE = 7'h00;
  localparam logic [6:0] ADDR_BUS_FORMAT = 7'h01;
  localparam logic [6:0] ADDR_DRIVER_POWER = 7'h02;
  localparam logic [6:0] ADDR_TIMING = 7'h03;
  localparam logic [6:0] ADDR_TERM_A = 7'h04;
  localparam logic [6:0] ADDR_TERM_B = 7'h05;
  localparam logic [6:0] ADDR_DIV_FORMAT = 7'h06;
  localparam logic [6:0] ADDR_RESERVED = 7'h07;
  localparam logic [6:0] ADDR_COMMON = 7'h08;
  localparam logic [6:0] ADDR_SOFT_RESET = 7'h0a;
  localparam int NUM_REGS = 9;

  // Reset values
  localparam logic [7:0] RST_POWER_STATE = 8'h03;
  localparam logic [7:0] RST_TIMING = 8'h80;
  localparam logic [7:0] RST_ZERO = 8'h00;

  // Writable bits; don't-care bits are dropped
  localparam logic [7:0] WMASK_DRIVER_POWER = 8'h0f;
  localparam logic [7:0] WMASK_TERM = 8'h3f;
  localparam logic [7:0] WMASK_ALL = 8'hff;

  localparam logic [7:0] SOFT_RESET_CODE = 8'h5a;

  // Field positions
  localparam int PS_AVG = 3;
  localparam int PS_STBY = 2;
  localparam int PS_B_ON = 1;
  localparam int PS_A_ON = 0;
  localparam int BF_REV_B = 4;
  localparam int BF_REV_A = 3;
  localparam int BF_BUS_SEL = 2;
  localparam int BF_INTERLEAVE = 1;
  localparam int DP_SLEEP_HI = 3;
  localparam int DP_SLEEP_LO = 2;
  localparam int DP_OVR_OFF = 1;
  localparam int DP_CLK_OFF = 0;
  localparam int DF_FMT_HI = 5;
  localparam int DF_FMT_LO = 4;
  localparam int DF_DIV_HI = 1;
  localparam int DF_DIV_LO = 0;
  // Status byte: bit 2 always reads one
  localparam logic [7:0] STATUS_FIXED = 8'h04;
  localparam int ST_ROM_BUSY = 5;
  localparam int ST_ROM_OK = 4;
  localparam int ST_DLL_LOCK = 0;

  // ----------------------------------------------------------------
  // Link framing and timing
  // ----------------------------------------------------------------
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [4:0] HEAD_BITS = 5'h08;
  localparam int CLK_MHZ = 25;
  localparam int SCLK_HALF_NS = 320;
  localparam logic [7:0] SCLK_HALF_CYC = 8'((SCLK_HALF_NS * CLK_MHZ) / 1000);

  // ----------------------------------------------------------------
  // Host controller AXI4-Lite map
  // ----------------------------------------------------------------
  localparam logic [7:0] HOST_CMD = 8'h00;
  localparam logic [7:0] HOST_STATUS = 8'h04;
  localparam logic [7:0] HOST_MODE = 8'h08;
  localparam int CMD_READ = 15;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Reset value of a register by index
  function automatic logic [7:0] reg_reset(input int idx);
    if (idx == int'(ADDR_POWER_STATE)) begin
      return RST_POWER_STATE;
    end
    if (idx == int'(ADDR_TIMING)) begin
      return RST_TIMING;
    end
    return RST_ZERO;
  endfunction : reg_reset

  // Writable bits of a register by address
  function automatic logic [7:0] reg_wmask(input logic [6:0] addr);
    unique case (addr)
      ADDR_DRIVER_POWER: return WMASK_DRIVER_POWER;
      ADDR_TERM_A, ADDR_TERM_B: return WMASK_TERM;
      default: return WMASK_ALL;
    endcase
  endfunction : reg_wmask

endpackage : adc_cfg_pkg

// File: common/adc_cfg_link_if.sv
// Three-wire link between host controller and configuration port.
// The shared data line is resolved here; an idle line floats high.
`timescale 1ns/1ps
`default_nettype none

interface adc_cfg_link_if;
  logic port_mode_select_n;
  logic cs_n;
  logic sclk;
  logic host_data_o;
  logic host_data_oe;
  logic dev_data_o;
  logic dev_data_oe;
  logic serial_data_io;

  // Device wins a clash; the bench flags clashes
  assign serial_data_io = dev_data_oe ? dev_data_o : (host_data_oe ? host_data_o : 1'b1);

  modport device (
    input port_mode_select_n, cs_n, sclk, serial_data_io,
    output dev_data_o, dev_data_oe
  );

  modport host (
    output port_mode_select_n, cs_n, sclk, host_data_o, host_data_oe,
    input serial_data_io
  );
endinterface : adc_cfg_link_if

`default_nettype wire

// File: rtl/adc_cfg_port.sv
// Device end: serial configuration port and control register bank.
// Assumes link pins are asynchronous; all are resynchronised to aclk.
`timescale 1ns/1ps
`default_nettype none

module adc_cfg_port (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Link to host
  adc_cfg_link_if.device link,
  // Shutdown pin and converter status
  input wire logic power_state_pin,
  input wire logic rom_busy,
  input wire logic rom_ok,
  input wire logic dll_locked,
  // Channel power
  output logic chan_a_run,
  output logic chan_a_standby,
  output logic chan_b_run,
  output logic chan_b_standby,
  output logic average_on,
  output logic average_on_bus_b,
  // Output bus arrangement
  output logic interleave_enable,
  output logic interleave_bus_select,
  output logic reverse_a,
  output logic reverse_b,
  output logic [1:0] data_format,
  output logic [1:0] clock_div_sel,
  // Output drivers
  output logic sleep_output_state_hi,
  output logic sleep_output_state_lo,
  output logic overrange_driver_off,
  output logic output_clock_driver_off,
  // Raw settings for the rest of the converter
  output logic [7:0] output_timing_adjust,
  output logic [7:0] chan_a_termination,
  output logic [7:0] chan_b_termination,
  output logic [7:0] divider_format_pattern,
  output logic [7:0] input_common_level
);

  // ----------------------------------------------------------------
  // Power state decode
  // ----------------------------------------------------------------
  // Returns {a_run, a_standby, b_run, b_standby, averaging}
  function automatic logic [4:0] power_decode(input logic [3:0] st);
    logic a_on;
    logic b_on;
    logic stby;
    a_on = st[adc_cfg_pkg::PS_A_ON];
    b_on = st[adc_cfg_pkg::PS_B_ON];
    stby = st[adc_cfg_pkg::PS_STBY];
    if (st[adc_cfg_pkg::PS_AVG] && (a_on || b_on)) begin
      return 5'b1_0101;
    end
    return {a_on, ~a_on & stby, b_on, ~b_on & stby, 1'b0};
  endfunction : power_decode

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] mode_s;
  logic [1:0] cs_s;
  logic [2:0] sclk_s;
  logic [1:0] sdi_s;
  logic [1:0] pin_s;

  // Two flops per pin; a third on the clock for edge finding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_s <= 2'b11;
      cs_s <= 2'b11;
      sclk_s <= 3'b000;
      sdi_s <= 2'b00;
      pin_s <= 2'b00;
    end else begin
      mode_s <= {mode_s[0], link.port_mode_select_n};
      cs_s <= {cs_s[0], link.cs_n};
      sclk_s <= {sclk_s[1:0], link.sclk};
      sdi_s <= {sdi_s[0], link.serial_data_io};
      pin_s <= {pin_s[0], power_state_pin};
    end
  end

  logic serial_on;
  logic sclk_rise;
  logic sclk_fall;
  assign serial_on = ~mode_s[1] & ~cs_s[1];
  assign sclk_rise = serial_on & sclk_s[1] & ~sclk_s[2];
  assign sclk_fall = serial_on & ~sclk_s[1] & sclk_s[2];

  // ----------------------------------------------------------------
  // Frame shifter
  // ----------------------------------------------------------------
  logic [4:0] cnt_q;
  logic [14:0] shift_q;

  // Counter clears whenever select is high, so a broken frame is dropped
  always_ff @(posedge aclk) begin
    if (!aresetn || !serial_on) begin
      cnt_q <= 5'h00;
      shift_q <= 15'h0000;
    end else if (sclk_rise && cnt_q != adc_cfg_pkg::FRAME_BITS) begin
      shift_q <= {shift_q[13:0], sdi_s[1]};
      cnt_q <= cnt_q + 5'h01;
    end
  end

  // Direction bit sits at the top of what has been shifted
  logic wr_go;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;
  logic rd_go;
  logic [6:0] rd_addr;
  assign wr_go = sclk_rise && cnt_q == adc_cfg_pkg::FRAME_BITS - 5'h01 && !shift_q[14];
  assign wr_addr = shift_q[13:7];
  assign wr_data = {shift_q[6:0], sdi_s[1]};
  assign rd_go = sclk_rise && cnt_q == adc_cfg_pkg::HEAD_BITS - 5'h01 && shift_q[6];
  assign rd_addr = {shift_q[5:0], sdi_s[1]};

  // ----------------------------------------------------------------
  // Register bank
  // ----------------------------------------------------------------
  logic [7:0] regs_q [0:adc_cfg_pkg::NUM_REGS-1];
  logic soft_reset;
  logic wr_valid;
  assign soft_reset = wr_go && wr_addr == adc_cfg_pkg::ADDR_SOFT_RESET &&
                      wr_data == adc_cfg_pkg::SOFT_RESET_CODE;
  // The reserved slot is never written
  assign wr_valid = wr_go && wr_addr < 7'(adc_cfg_pkg::NUM_REGS) &&
                    wr_addr != adc_cfg_pkg::ADDR_RESERVED;

  // Storage; soft reset restores the same defaults as power-on
  always_ff @(posedge aclk) begin
    if (!aresetn || soft_reset) begin
      for (int i = 0; i < adc_cfg_pkg::NUM_REGS; i++) begin
        regs_q[i] <= adc_cfg_pkg::reg_reset(i);
      end
    end else if (wr_valid) begin
      regs_q[wr_addr[3:0]] <= wr_data & adc_cfg_pkg::reg_wmask(wr_addr);
    end
  end

  // Read value by address; unmapped and reserved read zero
  function automatic logic [7:0] read_value(input logic [6:0] addr);
    logic [7:0] st;
    st = adc_cfg_pkg::STATUS_FIXED;
    st[adc_cfg_pkg::ST_ROM_BUSY] = rom_busy;
    st[adc_cfg_pkg::ST_ROM_OK] = rom_ok;
    st[adc_cfg_pkg::ST_DLL_LOCK] = dll_locked;
    if (addr == adc_cfg_pkg::ADDR_SOFT_RESET) begin
      return st;
    end
    if (addr < 7'(adc_cfg_pkg::NUM_REGS) && addr != adc_cfg_pkg::ADDR_RESERVED) begin
      return regs_q[addr[3:0]];
    end
    return 8'h00;
  endfunction : read_value

  // ----------------------------------------------------------------
  // Read-back driver
  // ----------------------------------------------------------------
  logic [7:0] rd_q;
  logic rd_mode_q;
  logic dev_oe_q;
  logic dev_o_q;

  // Value is frozen after the eighth rise; drive starts on the next fall
  always_ff @(posedge aclk) begin
    if (!aresetn || !serial_on) begin
      rd_q <= 8'h00;
      rd_mode_q <= 1'b0;
      dev_oe_q <= 1'b0;
      dev_o_q <= 1'b0;
    end else if (rd_go) begin
      rd_q <= read_value(rd_addr);
      rd_mode_q <= 1'b1;
    end else if (sclk_fall && rd_mode_q) begin
      dev_oe_q <= 1'b1;
      dev_o_q <= rd_q[7];
      rd_q <= {rd_q[6:0], 1'b0};
    end
  end
  assign link.dev_data_oe = dev_oe_q;
  assign link.dev_data_o = dev_o_q;

  // ----------------------------------------------------------------
  // Decoded outputs
  // ----------------------------------------------------------------
  logic [3:0] state_sel;
  logic [4:0] pwr;
  logic [7:0] fmt_r;
  logic [7:0] dpm_r;
  logic [7:0] div_r;
  assign state_sel = pin_s[1] ? regs_q[0][7:4] : regs_q[0][3:0];
  assign pwr = power_decode(state_sel);
  assign fmt_r = regs_q[adc_cfg_pkg::ADDR_BUS_FORMAT[3:0]];
  assign dpm_r = regs_q[adc_cfg_pkg::ADDR_DRIVER_POWER[3:0]];
  assign div_r = regs_q[adc_cfg_pkg::ADDR_DIV_FORMAT[3:0]];

  // Channel power follows the selected nibble
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {chan_a_run, chan_a_standby, chan_b_run, chan_b_standby, average_on} <= 5'b1_0100;
      average_on_bus_b <= 1'b0;
    end else begin
      {chan_a_run, chan_a_standby, chan_b_run, chan_b_standby, average_on} <= pwr;
      average_on_bus_b <= pwr[0] & fmt_r[adc_cfg_pkg::BF_BUS_SEL];
    end
  end

  // Bus arrangement; parallel mode reads levels only, so a floating
  // pin cannot be told apart from a driven one here
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      interleave_enable <= 1'b0;
      interleave_bus_select <= 1'b0;
      data_format <= 2'b00;
      clock_div_sel <= 2'b00;
    end else if (mode_s[1]) begin
      interleave_enable <= cs_s[1];
      interleave_bus_select <= 1'b0;
      data_format <= {1'b0, sdi_s[1]};
      clock_div_sel <= {1'b0, sclk_s[1]};
    end else begin
      interleave_enable <= fmt_r[adc_cfg_pkg::BF_INTERLEAVE];
      interleave_bus_select <= fmt_r[adc_cfg_pkg::BF_BUS_SEL];
      data_format <= div_r[adc_cfg_pkg::DF_FMT_HI:adc_cfg_pkg::DF_FMT_LO];
      clock_div_sel <= div_r[adc_cfg_pkg::DF_DIV_HI:adc_cfg_pkg::DF_DIV_LO];
    end
  end

  // Straight register fields
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reverse_a <= 1'b0;
      reverse_b <= 1'b0;
      sleep_output_state_hi <= 1'b0;
      sleep_output_state_lo <= 1'b0;
      overrange_driver_off <= 1'b0;
      output_clock_driver_off <= 1'b0;
    end else begin
      reverse_a <= fmt_r[adc_cfg_pkg::BF_REV_A];
      reverse_b <= fmt_r[adc_cfg_pkg::BF_REV_B];
      sleep_output_state_hi <= dpm_r[adc_cfg_pkg::DP_SLEEP_HI];
      sleep_output_state_lo <= dpm_r[adc_cfg_pkg::DP_SLEEP_LO];
      overrange_driver_off <= dpm_r[adc_cfg_pkg::DP_OVR_OFF];
      output_clock_driver_off <= dpm_r[adc_cfg_pkg::DP_CLK_OFF];
    end
  end

  // Raw settings straight from storage
  assign output_timing_adjust = regs_q[adc_cfg_pkg::ADDR_TIMING[3:0]];
  assign chan_a_termination = regs_q[adc_cfg_pkg::ADDR_TERM_A[3:0]];
  assign chan_b_termination = regs_q[adc_cfg_pkg::ADDR_TERM_B[3:0]];
  assign divider_format_pattern = div_r;
  assign input_common_level = regs_q[adc_cfg_pkg::ADDR_COMMON[3:0]];

endmodule : adc_cfg_port

`default_nettype wire

// File: rtl/adc_cfg_host.sv
// Host end: AXI4-Lite slave that runs one serial transfer per command.
// Assumes the device answers within one serial clock half period.
`timescale 1ns/1ps
`default_nettype none

module adc_cfg_host (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Link to device
  adc_cfg_link_if.host link
);

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_LEAD = 3'b001,
    S_HIGH = 3'b010,
    S_LOW = 3'b011,
    S_TAIL = 3'b100,
    S_GAP = 3'b101
  } link_state_e;
  link_state_e link_q;

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  logic aw_got_q;
  logic w_got_q;
  logic [7:0] aw_q;
  logic [31:0] w_q;
  logic ws_q;
  logic [3:0] mode_q;
  logic start;
  logic busy;
  assign busy = link_q != S_IDLE;

  // Address and data taken in either order; response after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      aw_q <= 8'h00;
      w_q <= 32'h0000_0000;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= adc_cfg_pkg::RESP_OKAY;
      mode_q <= 4'h0;
      ws_q <= 1'b0;
    end else begin
      awready <= awvalid && !aw_got_q && !awready && !bvalid;
      wready <= wvalid && !w_got_q && !wready && !bvalid;
      if (awvalid && awready) begin
        aw_got_q <= 1'b1;
        aw_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_got_q <= 1'b1;
        w_q <= wdata;
        ws_q <= wstrb[0];
      end
      if (aw_got_q && w_got_q) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        bvalid <= 1'b1;
        bresp <= adc_cfg_pkg::RESP_OKAY;
        if (aw_q == adc_cfg_pkg::HOST_MODE && ws_q) begin
          mode_q <= w_q[3:0];
        end else if (aw_q != adc_cfg_pkg::HOST_CMD && aw_q != adc_cfg_pkg::HOST_MODE) begin
          bresp <= adc_cfg_pkg::RESP_SLVERR;
        end
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end
  // A command while busy or in parallel mode is dropped
  assign start = aw_got_q && w_got_q && aw_q == adc_cfg_pkg::HOST_CMD &&
                 !busy && !mode_q[0];

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  logic [7:0] rx_q;
  logic [7:0] rd_byte_q;

  // One read in flight; rvalid follows the address by one cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= adc_cfg_pkg::RESP_OKAY;
    end else begin
      arready <= arvalid && !arready && !rvalid;
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rresp <= adc_cfg_pkg::RESP_OKAY;
        unique case (araddr)
          adc_cfg_pkg::HOST_STATUS: rdata <= {16'h0000, rd_byte_q, 7'h00, busy};
          adc_cfg_pkg::HOST_MODE: rdata <= {28'h000_0000, mode_q};
          default: begin
            rdata <= 32'h0000_0000;
            rresp <= (araddr == adc_cfg_pkg::HOST_CMD) ? adc_cfg_pkg::RESP_OKAY
                                                        : adc_cfg_pkg::RESP_SLVERR;
          end
        endcase
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Serial engine
  // ----------------------------------------------------------------
  logic [7:0] ph_q;
  logic tick;
  logic [1:0] sdi_s;
  logic [15:0] tx_q;
  logic [3:0] bit_q;
  logic rd_q;
  assign tick = ph_q == adc_cfg_pkg::SCLK_HALF_CYC - 8'h01;

  // Returned data crosses in from the device pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sdi_s <= 2'b00;
    end else begin
      sdi_s <= {sdi_s[0], link.serial_data_io};
    end
  end

  // Half-period divider for the serial clock
  always_ff @(posedge aclk) begin
    if (!aresetn || link_q == S_IDLE || tick) begin
      ph_q <= 8'h00;
    end else begin
      ph_q <= ph_q + 8'h01;
    end
  end

  // Sequencer; every transfer ends with select high for a gap
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_q <= S_IDLE;
      link.port_mode_select_n <= 1'b0;
      link.cs_n <= 1'b1;
      link.sclk <= 1'b0;
      link.host_data_o <= 1'b0;
      link.host_data_oe <= 1'b0;
      tx_q <= 16'h0000;
      bit_q <= 4'h0;
      rd_q <= 1'b0;
      rx_q <= 8'h00;
      rd_byte_q <= 8'h00;
    end else begin
      unique case (link_q)
        S_IDLE: begin
          link.port_mode_select_n <= mode_q[0];
          link.cs_n <= mode_q[0] ? mode_q[3] : 1'b1;
          link.sclk <= mode_q[0] & mode_q[2];
          link.host_data_o <= mode_q[0] & mode_q[1];
          link.host_data_oe <= mode_q[0];
          if (start) begin
            tx_q <= w_q[15:0];
            rd_q <= w_q[adc_cfg_pkg::CMD_READ];
            bit_q <= 4'h0;
            link.cs_n <= 1'b0;
            link.host_data_o <= w_q[15];
            link.host_data_oe <= 1'b1;
            link_q <= S_LEAD;
          end
        end
        S_LEAD, S_LOW: if (tick) begin
          link.sclk <= 1'b1;
          rx_q <= {rx_q[6:0], sdi_s[1]};
          link_q <= S_HIGH;
        end
        S_HIGH: if (tick) begin
          link.sclk <= 1'b0;
          bit_q <= bit_q + 4'h1;
          tx_q <= {tx_q[14:0], 1'b0};
          link.host_data_o <= tx_q[14];
          if (rd_q && bit_q >= 4'(adc_cfg_pkg::HEAD_BITS - 5'h01)) begin
            link.host_data_oe <= 1'b0;
          end
          link_q <= (bit_q == 4'hf) ? S_TAIL : S_LOW;
        end
        S_TAIL: if (tick) begin
          link.cs_n <= 1'b1;
          link.host_data_oe <= 1'b0;
          rd_byte_q <= rx_q;
          link_q <= S_GAP;
        end
        S_GAP: if (tick) begin
          link_q <= S_IDLE;
        end
        default: link_q <= S_IDLE;
      endcase
    end
  end

endmodule : adc_cfg_host

`default_nettype wire

// File: testbench/adc_cfg_sva.sv
// Checker for the three-wire link between the host and device ends.
// Assumes one aclk domain with a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module adc_cfg_sva (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Link signals
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic host_data_o,
  input wire logic host_data_oe,
  input wire logic dev_data_o,
  input wire logic dev_data_oe
);
  // ------------------------------------------------------------
  // Link properties
  // ------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Only one end may drive the shared line
  a_no_clash: assert property (!(dev_data_oe && host_data_oe))
    else $error("shared line driven by both ends");
  a_idle_quiet: assert property (cs_n [*5] |-> !dev_data_oe && !sclk)
    else $error("link active while deselected");
  a_cs_gap: assert property ($rose(cs_n) |=> cs_n [*7])
    else $error("select gap too short");
  a_sclk_half: assert property ($rose(sclk) |=> sclk [*7] ##1 !sclk)
    else $error("serial clock high phase wrong");
  a_rise_framed: assert property ($rose(sclk) |-> !cs_n)
    else $error("serial clock rise outside frame");
  a_host_shift: assert property (host_data_oe && $changed(host_data_o) |-> !sclk)
    else $error("host data changed while clock high");
  a_dev_start: assert property ($rose(dev_data_oe) |-> !cs_n && !sclk)
    else $error("device drive began off a falling phase");
  a_dev_shift: assert property (dev_data_oe && $past(dev_data_oe) && $changed(dev_data_o)
    |-> !sclk)
    else $error("device data changed while clock high");
  // Main scenarios reached
  c_read_back: cover property ($rose(dev_data_oe));
  c_frame_end: cover property ($rose(cs_n));
  c_host_bit: cover property (host_data_oe && $rose(sclk));
endmodule : adc_cfg_sva
`default_nettype wire

// File: testbench/adc_serial_config_port_tb_top.sv
// Bench joining host and device ends; a register model checks read data and decoded outputs.
// Assumes the host AXI map and status fields of the package.
`timescale 1ns/1ps
`default_nettype none
module adc_serial_config_port_tb_top;
  logic aclk = 0;
  logic aresetn = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0;
  logic [3:0] wstrb = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, br;
  logic [31:0] rdata;
  logic power_state_pin = 0, rom_busy = 0, rom_ok = 0, dll_locked = 0;
  logic chan_a_run, chan_a_standby, chan_b_run, chan_b_standby, average_on, average_on_bus_b;
  logic interleave_enable, interleave_bus_select, reverse_a, reverse_b;
  logic sleep_output_state_hi, sleep_output_state_lo, overrange_driver_off;
  logic output_clock_driver_off;
  logic [1:0] data_format, clock_div_sel;
  logic [17:0] outs;
  logic [7:0] m [0:8];
  int errors = 0, checks_done = 0;
  adc_cfg_link_if link ();
  always #20 aclk = ~aclk;
  // Both ends face each other across the one link
  adc_cfg_host adc_cfg_host_inst (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .link(link));
  adc_cfg_port adc_cfg_port_inst (.aclk, .aresetn, .link(link), .power_state_pin, .rom_busy,
    .rom_ok, .dll_locked, .chan_a_run, .chan_a_standby, .chan_b_run, .chan_b_standby,
    .average_on, .average_on_bus_b, .interleave_enable, .interleave_bus_select, .reverse_a,
    .reverse_b, .data_format, .clock_div_sel, .sleep_output_state_hi, .sleep_output_state_lo,
    .overrange_driver_off, .output_clock_driver_off, .output_timing_adjust(),
    .chan_a_termination(), .chan_b_termination(), .divider_format_pattern(),
    .input_common_level());
  adc_cfg_sva adc_cfg_sva_inst (.aclk, .aresetn, .cs_n(link.cs_n), .sclk(link.sclk),
    .host_data_o(link.host_data_o), .host_data_oe(link.host_data_oe),
    .dev_data_o(link.dev_data_o), .dev_data_oe(link.dev_data_oe));
  // Decoded settings gathered into one vector for comparison
  assign outs = {chan_a_run, chan_a_standby, chan_b_run, chan_b_standby, average_on,
    average_on_bus_b, reverse_b, reverse_a, interleave_bus_select, interleave_enable,
    sleep_output_state_hi, sleep_output_state_lo, overrange_driver_off,
    output_clock_driver_off, data_format, clock_div_sel};
  // ------------------------------------------------------------
  // Model and bus tasks
  // ------------------------------------------------------------
  function automatic logic [7:0] rv(input int a);
    return a == 0 ? 8'h03 : (a == 3 ? 8'h80 : 8'h00);
  endfunction : rv
  function automatic logic [7:0] exp(input int a);
    if (a == 10) return {2'b00, rom_busy, rom_ok, 3'b010, dll_locked};
    return (a < 9 && a != 7) ? m[a] : 8'h00;
  endfunction : exp
  function automatic logic [17:0] want();
    logic [3:0] p;
    logic av, ra, rb;
    p = power_state_pin ? m[0][7:4] : m[0][3:0];
    av = p[3] & (p[0] | p[1]);
    ra = p[0] | av;
    rb = p[1] | av;
    return {ra, ~ra & p[2], rb, ~rb & p[2], av, av & m[1][2], m[1][4:1], m[2][3:0],
      m[6][5:4], m[6][1:0]};
  endfunction : want
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 99);
    br = bresp;
    if (n == 99) errors++;
    bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 99);
    if (n == 99) errors++;
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axr
  // One serial frame through the host, then wait for it to finish
  task automatic dev(input logic rd, input logic [6:0] a, input logic [7:0] d,
    output logic [7:0] q);
    logic [31:0] s;
    logic [1:0] r;
    int n = 0;
    axw(adc_cfg_pkg::HOST_CMD, {16'h0000, rd, a, d});
    do begin
      axr(adc_cfg_pkg::HOST_STATUS, s, r);
      n++;
    end while (s[0] !== 1'b0 && n < 999);
    if (n == 999) errors++;
    q = s[15:8];
  endtask : dev
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  // Watchdog sized well above the expected run
  initial begin
    #2_000_000;
    errors++;
    finish_test();
  end
  // First pass reads every default, then random traffic
  initial begin
    int a;
    logic [7:0] d, q;
    logic rd;
    logic [31:0] s;
    logic [1:0] r;
    void'($urandom(32'h0000_cd9c));
    for (int i = 0; i < 9; i++) m[i] = rv(i);
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    axr(8'h0c, s, r);
    chk("unmapped response", r, adc_cfg_pkg::RESP_SLVERR);
    // Parallel mode: select pin high, data pin high, clock pin low
    axw(adc_cfg_pkg::HOST_MODE, 32'h0000_000b);
    chk("mode response", br, adc_cfg_pkg::RESP_OKAY);
    repeat (8) @(posedge aclk);
    chk("parallel pins", {outs[9:8], outs[3:0]}, 6'h14);
    axw(adc_cfg_pkg::HOST_MODE, 32'h0000_0000);
    for (int i = 0; i < 60; i++) begin
      a = i < 11 ? i : int'($urandom % 11);
      rd = i < 11 ? 1'b1 : 1'($urandom);
      d = 8'($urandom);
      if (a == 1) d = d & 8'h1e;
      if (a == 10 && d[0]) d = 8'h5a;
      power_state_pin <= 1'($urandom);
      {rom_busy, rom_ok, dll_locked} <= 3'($urandom);
      dev(rd, 7'(a), d, q);
      if (rd) chk("read data", q, exp(a));
      else if (a == 10 && d == 8'h5a) for (int k = 0; k < 9; k++) m[k] = rv(k);
      else if (a < 9 && a != 7) m[a] = d & (a == 2 ? 8'h0f : (a == 4 || a == 5) ? 8'h3f : 8'hff);
      repeat (4) @(posedge aclk);
      chk("decoded outputs", outs, want());
    end
    finish_test();
  end
endmodule : adc_serial_config_port_tb_top
`default_nettype wire
